/* File: logic/acc_analog_comparator.sv */
// Control and status logic for three analog comparator instances.
// Assumes analog levels arrive as unsigned codes and sleep state comes
// from the clock controller on the peripheral clock domain.
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_analog_comparator #(
    parameter int NUM_INST = 3,
    parameter int LEVEL_W = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [LEVEL_W-1:0] posPinLevel [NUM_INST][4],
    input wire logic [LEVEL_W-1:0] negPinLevel [NUM_INST][2],
    input wire logic [LEVEL_W-1:0] dacLevel [NUM_INST],
    input wire logic [LEVEL_W-1:0] vrefLevel,
    input wire logic [2:0] sleepMode,
    input wire logic periphClockKept,
    output logic [NUM_INST-1:0] compareEvent,
    output logic [NUM_INST-1:0] padOut,
    output logic [NUM_INST-1:0] padOutEnable,
    output logic [NUM_INST-1:0] analogEnable,
    output logic [NUM_INST-1:0] lowPowerSelect,
    output logic [1:0] hysteresisSelect [NUM_INST],
    output logic [NUM_INST-1:0] compareIrq
);
    initial
    begin
        if (NUM_INST < 1 || NUM_INST > 3 || LEVEL_W < 1)
            $error("Unsupported comparator parameters");
    end

    logic [7:0] control [NUM_INST];
    logic [7:0] select [NUM_INST];
    logic [NUM_INST-1:0] irqEnable;
    logic [NUM_INST-1:0] irqFlag;
    logic [NUM_INST-1:0] result;
    logic [NUM_INST-1:0] syncA, syncB, syncC, syncPrev;
    logic [NUM_INST-1:0] edgeHit;
    logic [NUM_INST-1:0] flagClear;
    logic statusRun;
    logic standbyStop;
    logic powerDown;

    // Bus-side state
    logic awHeld, wHeld;
    logic [31:0] awAddrHeld;
    logic [7:0] wByteHeld;
    logic wLaneHeld;
    logic doWrite;
    logic rdHit;
    logic [7:0] rdByte;

    function automatic logic addrMapped(input logic [31:0] a);
        addrMapped = a[31:7] == 25'h0 && a[1:0] == 2'h0 &&
            int'(a[6:5]) < NUM_INST &&
            (a[4:2] == `ACC_IDX_CONTROL || a[4:2] == `ACC_IDX_SELECT ||
             a[4:2] == `ACC_IDX_IRQEN || a[4:2] == `ACC_IDX_STATUS);
    endfunction

    // Sleep decode; debug halt has no input here at all
    assign powerDown = sleepMode == acc_pkg::ACC_SLP_POWERDOWN;
    assign standbyStop = sleepMode == acc_pkg::ACC_SLP_STANDBY;
    // Status keeps running in idle, frozen in standby or power-down without a clock
    assign statusRun = !(powerDown || standbyStop) ||
        periphClockKept;

    // Analog path: purely combinational so events see no clock
    always_comb
    begin
        for (int i = 0; i < NUM_INST; i++)
        begin
            logic [LEVEL_W-1:0] posV;
            logic [LEVEL_W-1:0] negV;
            logic run;
            negV = '0;
            posV = posPinLevel[i][select[i][`ACC_SEL_POS_LO +: 2]];
            case (acc_pkg::acc_neg_t'(select[i][`ACC_SEL_NEG_LO +: 2]))
                acc_pkg::ACC_NEG_PIN0: negV = negPinLevel[i][0];
                acc_pkg::ACC_NEG_PIN1: negV = negPinLevel[i][1];
                acc_pkg::ACC_NEG_VREF: negV = vrefLevel;
                acc_pkg::ACC_NEG_DAC: negV = dacLevel[i];
                default: negV = negPinLevel[i][0];
            endcase
            run = control[i][`ACC_CTL_ENABLE] && !powerDown &&
                !(standbyStop && !control[i][`ACC_CTL_RUNSTBY]);
            analogEnable[i] = run;
            // Disabled comparator reads low, before inversion
            result[i] = ((posV > negV) && run) ^
                select[i][`ACC_SEL_INVERT];
            compareEvent[i] = result[i] && run;
            padOut[i] = result[i];
            padOutEnable[i] = control[i][`ACC_CTL_PADOE] && run;
            lowPowerSelect[i] = control[i][`ACC_CTL_LOWPWR];
            hysteresisSelect[i] = control[i][`ACC_CTL_HYS_LO +: 2];
        end
    end

    // Three-deep synchroniser plus a history stage; only syncC and syncPrev feed logic
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            syncPrev <= '0;
        end
        else if (statusRun)
        begin
            // State bit is status too, so it freezes along with the flag
            syncA <= result;
            syncB <= syncA;
            syncC <= syncB;
            syncPrev <= syncC;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_INST; i++)
        begin
            case (acc_pkg::acc_edge_t'(control[i][`ACC_CTL_EDGE_LO +: 2]))
                acc_pkg::ACC_EDGE_BOTH: edgeHit[i] = syncC[i] != syncPrev[i];
                acc_pkg::ACC_EDGE_FALL: edgeHit[i] = !syncC[i] && syncPrev[i];
                acc_pkg::ACC_EDGE_RISE: edgeHit[i] = syncC[i] && !syncPrev[i];
                default: edgeHit[i] = 1'b0;
            endcase
            edgeHit[i] = edgeHit[i] && statusRun;
        end
    end

    // Write path: address and data taken in either order
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign doWrite = awHeld && wHeld && !bvalid;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= 32'h0000_0000;
            wByteHeld <= 8'h00;
            wLaneHeld <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                awHeld <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready)
            begin
                wHeld <= 1'b1;
                wByteHeld <= wdata[7:0];
                wLaneHeld <= wstrb[0];
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= addrMapped(awAddrHeld) ? 2'h0 : 2'h2;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_INST; i++)
            flagClear[i] = doWrite && wLaneHeld && addrMapped(awAddrHeld) &&
                int'(awAddrHeld[6:5]) == i &&
                awAddrHeld[4:2] == `ACC_IDX_STATUS &&
                wByteHeld[`ACC_STS_FLAG];
    end

    // Configuration registers, one block per instance
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_INST; i++)
        begin
            if (reset)
            begin
                control[i] <= `ACC_RST_CONTROL;
                select[i] <= `ACC_RST_SELECT;
                irqEnable[i] <= 1'b0;
            end
            else if (doWrite && wLaneHeld && addrMapped(awAddrHeld) &&
                int'(awAddrHeld[6:5]) == i)
            begin
                case (awAddrHeld[4:2])
                    `ACC_IDX_CONTROL: control[i] <= wByteHeld;
                    `ACC_IDX_SELECT:
                        select[i] <= wByteHeld & `ACC_MASK_SELECT;
                    `ACC_IDX_IRQEN: irqEnable[i] <= wByteHeld[0];
                    default: ;
                endcase
            end
        end
    end

    // Sticky flag: a new edge beats a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (reset)
            irqFlag <= '0;
        else
            irqFlag <= edgeHit | (irqFlag & ~flagClear);
    end

    assign compareIrq = irqFlag & irqEnable;

    // Read path: answer one cycle after the address is taken
    assign arready = !rvalid;

    always_comb
    begin
        int k;
        k = int'(araddr[6:5]);
        rdHit = addrMapped(araddr);
        rdByte = 8'h00;
        if (rdHit)
        begin
            case (araddr[4:2])
                `ACC_IDX_CONTROL: rdByte = control[k];
                `ACC_IDX_SELECT: rdByte = select[k];
                `ACC_IDX_IRQEN: rdByte = {7'h00, irqEnable[k]};
                `ACC_IDX_STATUS:
                    rdByte = {3'h0, syncC[k], 3'h0, irqFlag[k]};
                default: rdByte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rdByte};
            rresp <= rdHit ? 2'h0 : 2'h2;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // Checks on instance 0, plus one on the read channel
    flag_on_edge_a: assert property (
        @(posedge clk) disable iff (reset)
        edgeHit[0] |=> irqFlag[0])
        else $error("Edge did not set flag");

    flag_clear_a: assert property (
        @(posedge clk) disable iff (reset)
        flagClear[0] && !edgeHit[0] |=> !irqFlag[0])
        else $error("Flag not cleared by write of one");

    flag_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        irqFlag[0] && !flagClear[0] |=> irqFlag[0])
        else $error("Flag dropped without a clear");

    irq_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        compareIrq[0] && !flagClear[0] && !(doWrite &&
            awAddrHeld[6:2] == {2'h0, `ACC_IDX_IRQEN}) |=> compareIrq[0])
        else $error("Request dropped before flag cleared");

    state_delay_a: assert property (
        @(posedge clk) disable iff (reset)
        (result[0] && statusRun)[*3] |=> syncC[0])
        else $error("State bit not three cycles behind");

    rise_only_a: assert property (
        @(posedge clk) disable iff (reset)
        control[0][5:4] == 2'h3 && syncC[0] && !syncPrev[0] && statusRun
        |=> irqFlag[0])
        else $error("Rising edge missed");

    no_fall_a: assert property (
        @(posedge clk) disable iff (reset)
        control[0][5:4] == 2'h3 && !syncC[0] |-> !edgeHit[0])
        else $error("Falling edge flagged in rise mode");

    pad_off_a: assert property (
        @(posedge clk) disable iff (reset)
        powerDown |-> !padOutEnable[0] && !analogEnable[0])
        else $error("Pad or comparator on in power-down");

    freeze_a: assert property (
        @(posedge clk) disable iff (reset)
        !statusRun && !flagClear[0] |=> irqFlag[0] == $past(irqFlag[0]))
        else $error("Flag moved while frozen");

    state_freeze_a: assert property (
        @(posedge clk) disable iff (reset)
        !statusRun |=> $stable(syncC[0]))
        else $error("State bit moved while frozen");

    bus_resp_a: assert property (
        @(posedge clk) disable iff (reset)
        arvalid && arready |=> rvalid)
        else $error("Read answer late");
endmodule

/* File: shared/acc_pkg.sv */
// Types for the comparator controller.
// Assumes nothing beyond the register header.
package acc_pkg;
    typedef enum logic [1:0]
    {
        ACC_EDGE_BOTH = 2'h0,
        ACC_EDGE_RSVD = 2'h1,
        ACC_EDGE_FALL = 2'h2,
        ACC_EDGE_RISE = 2'h3
    } acc_edge_t;
    typedef enum logic [1:0]
    {
        ACC_NEG_PIN0 = 2'h0,
        ACC_NEG_PIN1 = 2'h1,
        ACC_NEG_VREF = 2'h2,
        ACC_NEG_DAC = 2'h3
    } acc_neg_t;
    typedef enum logic [2:0]
    {
        ACC_SLP_ACTIVE = 3'h1,
        ACC_SLP_STANDBY = 3'h2,
        ACC_SLP_POWERDOWN = 3'h4
    } acc_sleep_t;
endpackage

/* File: shared/acc_regs.svh */
// Register map and timing constants for the comparator controller.
// Assumes byte addresses on AXI4-Lite, one 32-bit word per register.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
// Register indices; byte address is four times the index
`define ACC_IDX_CONTROL 3'h0
`define ACC_IDX_SELECT 3'h2
`define ACC_IDX_IRQEN 3'h6
`define ACC_IDX_STATUS 3'h7
// Instance block stride in bytes (address bits 6:5)
`define ACC_INST_STRIDE 8'h20
// Control fields
`define ACC_CTL_ENABLE 0
`define ACC_CTL_HYS_LO 1
`define ACC_CTL_LOWPWR 3
`define ACC_CTL_EDGE_LO 4
`define ACC_CTL_PADOE 6
`define ACC_CTL_RUNSTBY 7
// Select fields
`define ACC_SEL_NEG_LO 0
`define ACC_SEL_POS_LO 3
`define ACC_SEL_INVERT 7
// Status fields
`define ACC_STS_FLAG 0
`define ACC_STS_STATE 4
// Reset values
`define ACC_RST_CONTROL 8'h00
`define ACC_RST_SELECT 8'h00
`define ACC_RST_IRQEN 8'h00
// Writable masks
`define ACC_MASK_SELECT 8'h9B
`define ACC_MASK_IRQEN 8'h01
// Interrupt vector offset within the block
`define ACC_VECTOR_OFFSET 8'h00
// Start-up times in ns, for software guidance
`define ACC_STARTUP_NS 2500
`define ACC_STARTUP_REF_NS 60000
`define ACC_CLK_NS 20
`define ACC_STARTUP_CYC ((`ACC_STARTUP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_STARTUP_REF_CYC \
    ((`ACC_STARTUP_REF_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

/* File: test/acc_analog_comparator_tb.sv */
// Self-checking bench for the three-instance comparator controller.
// Assumes the register header and the AXI4-Lite timing of the design.
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_analog_comparator_tb;
    logic clk, reset;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [9:0] posLvl [3][4];
    logic [9:0] negLvl [3][2];
    logic [9:0] dacLvl [3];
    logic [9:0] vrefLvl;
    logic [2:0] sleepMode;
    logic periphClockKept;
    logic [2:0] compareEvent, padOut, padOutEnable, analogEnable;
    logic [2:0] lowPowerSelect, compareIrq;
    logic [1:0] hysteresisSelect [3];
    logic [2:0] idxList [4];
    int errors = 0;
    int tests_run = 0;

    acc_analog_comparator i_acc_analog_comparator (
        .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .posPinLevel(posLvl), .negPinLevel(negLvl), .dacLevel(dacLvl),
        .vrefLevel(vrefLvl), .sleepMode(sleepMode),
        .periphClockKept(periphClockKept), .compareEvent(compareEvent),
        .padOut(padOut), .padOutEnable(padOutEnable),
        .analogEnable(analogEnable), .lowPowerSelect(lowPowerSelect),
        .hysteresisSelect(hysteresisSelect), .compareIrq(compareIrq)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    function automatic logic [31:0] regAddr(input int inst,
        input logic [2:0] idx);
        return 32'(inst) * 32'h00000020 + {27'h0000000, idx, 2'h0};
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Bready and rready stay high, so a seen valid is a completed transfer
    task automatic wr(input int inst, input logic [2:0] idx,
        input logic [7:0] d, input logic [1:0] expResp);
        int n;
        n = 0;
        awaddr <= regAddr(inst, idx);
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        chk(bvalid ? {30'h0, bresp} : 32'hFFFFFFFF, {30'h0, expResp});
    endtask

    task automatic rd(input int inst, input logic [2:0] idx,
        input logic [31:0] expData, input logic [1:0] expResp);
        int n;
        n = 0;
        araddr <= regAddr(inst, idx);
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        chk(rvalid ? rdata : 32'hFFFFFFFF, expData);
        chk({30'h0, rresp}, {30'h0, expResp});
    endtask

    task automatic test_regs();
        for (int i = 0; i < 3; i++)
            foreach (idxList[k]) rd(i, idxList[k], 32'h0, 2'h0);
        wr(2, `ACC_IDX_SELECT, 8'hFF, 2'h0);
        rd(2, `ACC_IDX_SELECT, 32'h0000009B, 2'h0);
        wr(2, `ACC_IDX_IRQEN, 8'hFF, 2'h0);
        rd(2, `ACC_IDX_IRQEN, 32'h00000001, 2'h0);
        rd(0, `ACC_IDX_CONTROL, 32'h0, 2'h0);
        rd(0, 3'h1, 32'h0, 2'h2);
        wr(0, 3'h1, 8'hFF, 2'h2);
        wstrb <= 4'hE;
        wr(0, `ACC_IDX_CONTROL, 8'hFF, 2'h0);
        wstrb <= 4'hF;
        rd(0, `ACC_IDX_CONTROL, 32'h0, 2'h0);
        wr(2, `ACC_IDX_SELECT, 8'h00, 2'h0);
        wr(2, `ACC_IDX_IRQEN, 8'h00, 2'h0);
    endtask

    task automatic test_mux();
        logic [9:0] negv [4];
        negv = '{10'h190, 10'h032, 10'h258, 10'h0FA};
        posLvl[1] <= '{10'h064, 10'h12C, 10'h1F4, 10'h2BC};
        negLvl[1] <= '{10'h190, 10'h032};
        vrefLvl <= 10'h258;
        dacLvl[1] <= 10'h0FA;
        wr(1, `ACC_IDX_SELECT, 8'h00, 2'h0);
        wr(1, `ACC_IDX_CONTROL, 8'h01, 2'h0);
        // Reference start-up is the longer wait, and vref is used below
        cyc(`ACC_STARTUP_REF_CYC);
        for (int p = 0; p < 4; p++)
            for (int n = 0; n < 4; n++)
            begin
                wr(1, `ACC_IDX_SELECT, {3'h0, p[1:0], 1'b0, n[1:0]}, 2'h0);
                chk(compareEvent[1], posLvl[1][p] > negv[n]);
            end
        // Pos 300 against neg 400: raw low, so inversion must show high
        wr(1, `ACC_IDX_CONTROL, 8'h41, 2'h0);
        wr(1, `ACC_IDX_SELECT, 8'h88, 2'h0);
        chk({compareEvent[1], padOut[1], padOutEnable[1]}, 3'h7);
        wr(1, `ACC_IDX_SELECT, 8'h08, 2'h0);
        chk({compareEvent[1], padOut[1], padOutEnable[1]}, 3'h1);
        wr(1, `ACC_IDX_CONTROL, 8'h00, 2'h0);
        chk({analogEnable[1], padOutEnable[1]}, 2'h0);
    endtask

    task automatic test_edges();
        logic rise, fall;
        negLvl[0][0] <= 10'h0C8;
        posLvl[0][0] <= 10'h064;
        for (int m = 0; m < 4; m++)
        begin
            rise = (m == 0 || m == 3);
            fall = (m == 0 || m == 2);
            wr(0, `ACC_IDX_IRQEN, {7'h00, m != 2}, 2'h0);
            wr(0, `ACC_IDX_CONTROL, {2'h0, m[1:0], 4'h1}, 2'h0);
            cyc(6);
            wr(0, `ACC_IDX_STATUS, 8'h01, 2'h0);
            rd(0, `ACC_IDX_STATUS, 32'h0, 2'h0);
            posLvl[0][0] <= 10'h12C;
            cyc(6);
            rd(0, `ACC_IDX_STATUS, {27'h0, 1'b1, 3'h0, rise}, 2'h0);
            chk(compareIrq[0], rise && m != 2);
            wr(0, `ACC_IDX_STATUS, 8'h01, 2'h0);
            chk(compareIrq[0], 1'b0);
            posLvl[0][0] <= 10'h064;
            cyc(6);
            rd(0, `ACC_IDX_STATUS, {31'h0, fall}, 2'h0);
            wr(0, `ACC_IDX_STATUS, 8'h01, 2'h0);
        end
    endtask

    task automatic test_sleep();
        wr(1, `ACC_IDX_SELECT, 8'h09, 2'h0);
        wr(1, `ACC_IDX_CONTROL, 8'h41, 2'h0);
        sleepMode <= 3'h2;
        @(posedge clk);
        chk({analogEnable[1], compareEvent[1]}, 2'h0);
        sleepMode <= 3'h1;
        wr(1, `ACC_IDX_CONTROL, 8'hC1, 2'h0);
        cyc(6);
        wr(1, `ACC_IDX_STATUS, 8'h01, 2'h0);
        sleepMode <= 3'h2;
        @(posedge clk);
        chk({analogEnable[1], compareEvent[1], padOut[1]}, 3'h7);
        posLvl[1][1] <= 10'h000;
        cyc(6);
        chk({compareEvent[1], padOut[1]}, 2'h0);
        rd(1, `ACC_IDX_STATUS, 32'h00000010, 2'h0);
        periphClockKept <= 1'b1;
        cyc(6);
        rd(1, `ACC_IDX_STATUS, 32'h00000001, 2'h0);
        periphClockKept <= 1'b0;
        sleepMode <= 3'h4;
        @(posedge clk);
        chk({analogEnable[1], padOutEnable[1]}, 2'h0);
        sleepMode <= 3'h1;
        wr(1, `ACC_IDX_CONTROL, 8'h00, 2'h0);
    endtask

    task automatic test_cfg();
        for (int h = 0; h < 4; h++)
        begin
            wr(2, `ACC_IDX_CONTROL, {5'h01, h[1:0], 1'b0}, 2'h0);
            chk({lowPowerSelect[2], hysteresisSelect[2]},
                {1'b1, h[1:0]});
        end
        wr(2, `ACC_IDX_CONTROL, 8'h00, 2'h0);
        chk(lowPowerSelect[2], 1'b0);
    endtask

    initial
    begin
        idxList = '{`ACC_IDX_CONTROL, `ACC_IDX_SELECT, `ACC_IDX_IRQEN,
            `ACC_IDX_STATUS};
        reset = 1'b1;
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, arvalid} = '0;
        bready = 1'b1;
        rready = 1'b1;
        wstrb = 4'hF;
        foreach (posLvl[i, j]) posLvl[i][j] = 10'h000;
        foreach (negLvl[i, j]) negLvl[i][j] = 10'h3FF;
        foreach (dacLvl[i]) dacLvl[i] = 10'h3FF;
        vrefLvl = 10'h3FF;
        sleepMode = 3'h1;
        periphClockKept = 1'b0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        test_regs();
        test_mux();
        test_edges();
        test_sleep();
        test_cfg();
        tally_and_finish();
    end

    // Whole run needs about 3300 cycles, start-up wait included
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule
